// ===== rtl/arm_defines.svh
// Offsets, field positions, reset values and codes for the reference/monitor/gain block
`ifndef ARM_DEFINES_SVH
`define ARM_DEFINES_SVH
`define ARM_OFF_REF_MON      4'h2
`define ARM_OFF_GAIN_RATE    4'h3
`define ARM_RST_REF_MON      8'h00
`define ARM_RST_GAIN_RATE    8'h00
`define ARM_REFCTL_HI        6
`define ARM_REFCTL_LO        5
`define ARM_REFSEL_HI        4
`define ARM_REFSEL_LO        3
`define ARM_MON_HI           2
`define ARM_MON_LO           0
`define ARM_GAIN_HI          6
`define ARM_GAIN_LO          4
`define ARM_RATE_HI          3
`define ARM_RATE_LO          0
`define ARM_CLKSTAT_BIT      7
`define ARM_GAIN_RSVD_BIT    7
`define ARM_REFCTL_OFF       2'h0
`define ARM_REFCTL_ON        2'h1
`define ARM_REFSEL_PAIR0     2'h0
`define ARM_REFSEL_PAIR1     2'h1
`define ARM_REFSEL_INT       2'h2
`define ARM_REFSEL_INT_DRV   2'h3
`define ARM_RATE_MAX_CODE    4'h8
`endif

// ===== rtl/arm_pkg.sv
// Types shared by the reference/monitor/gain register block
package arm_pkg;
  typedef enum logic [2:0] {
    ARM_MON_NORMAL  = 3'h0,
    ARM_MON_OFFSET  = 3'h1,
    ARM_MON_GAIN    = 3'h2,
    ARM_MON_TEMP    = 3'h3,
    ARM_MON_REF1    = 3'h4,
    ARM_MON_REF0    = 3'h5,
    ARM_MON_AVDD    = 3'h6,
    ARM_MON_DVDD    = 3'h7
  } arm_mon_e;

  typedef enum logic [2:0] {
    ARM_ROUTE_CHANNEL = 3'b001,
    ARM_ROUTE_MIDSUP  = 3'b010,
    ARM_ROUTE_INTERNAL = 3'b100
  } arm_route_e;

  typedef struct packed {
    logic       ref_power;
    logic [1:0] ref_input_select;
    logic       drive_ref_pair0;
    logic       override_active;
    arm_route_e route;
    arm_mon_e   source;
    logic [7:0] gain;
    logic [3:0] rate_index;
  } arm_ctrl_s;
endpackage : arm_pkg

// ===== rtl/arm_wb_slave.sv
// Classic Wishbone slave: single-cycle ack, byte-wide registers in the low lane
`timescale 1ns/1ps
`include "arm_defines.svh"
module arm_wb_slave (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Register side
  output logic             wr_ref_mon,
  output logic             wr_gain_rate,
  output logic      [7:0]  wr_data,
  input  wire logic [7:0]  rd_ref_mon,
  input  wire logic [7:0]  rd_gain_rate
);
  wire       req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [3:0] idx       = wb_adr_i[5:2];
  wire       hit_mon   = (idx == `ARM_OFF_REF_MON);
  wire       hit_gain  = (idx == `ARM_OFF_GAIN_RATE);
  wire       lane0_wr  = req & wb_we_i & wb_sel_i[0];
  wire [7:0] rd_mux    = hit_mon ? rd_ref_mon : hit_gain ? rd_gain_rate : 8'h00;

  assign wr_ref_mon   = lane0_wr & hit_mon;
  assign wr_gain_rate = lane0_wr & hit_gain;
  assign wr_data      = wb_dat_i[7:0];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end
endmodule : arm_wb_slave

// ===== rtl/arm_regs.sv
// Reference, system-monitor, gain and rate configuration registers
// How it works
// - Reference control 00 keeps internal reference off; 01 keeps it on.
// - Codes 10/11 power reference once a conversion starts and keep it on; sleep or start low drops it.
// - Reference select: 00 pair0, 01 pair1, 10 internal, 11 internal driven on pair0.
// - Any non-normal monitor code overrides channel, bias and reference selections.
// - Monitor 000 normal routing; 001 shorts converter inputs to mid-supply.
// - Monitor 010 connects converter inputs to selected reference for gain calibration.
// - Monitor 011 routes converter inputs to the temperature diode.
// - Monitor 100 applies quarter of pair1 voltage; 101 quarter of pair0.
// - Monitor 110 applies quarter analog supply; 111 quarter digital supply.
// - Monitor codes 010..111 force gain 1; 000/001 use stored gain code.
// - Gain field bits 6:4 selects gain of two to the code power.
// - Rate field bits 3:0 sets output rate; codes 1001..1111 all give 2000.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "arm_defines.svh"
module arm_regs
  import arm_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // Wishbone
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [5:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Device state
  input  wire logic                ext_clock_in_use,
  input  wire logic                conversion_active,
  input  wire logic                sleep_cmd,
  input  wire logic                start_pin,
  // Analog front-end controls
  output arm_pkg::arm_ctrl_s       ctrl,
  output logic [15:0]              output_rate_sps
);
  import arm_pkg::*;

  logic [1:0] internal_ref_control;
  logic [1:0] ref_input_select;
  logic [2:0] system_monitor_select;
  logic [2:0] amp_gain_code;
  logic [3:0] output_rate_code;
  logic       clk_status;
  logic       follow_on;

  logic       wr_ref_mon;
  logic       wr_gain_rate;
  logic [7:0] wr_data;
  logic [7:0] rd_ref_mon;
  logic [7:0] rd_gain_rate;

  arm_wb_slave u_bus (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .wr_ref_mon   (wr_ref_mon),
    .wr_gain_rate (wr_gain_rate),
    .wr_data      (wr_data),
    .rd_ref_mon   (rd_ref_mon),
    .rd_gain_rate (rd_gain_rate)
  );

  // Readback
  assign rd_ref_mon   = {clk_status, internal_ref_control, ref_input_select,
                         system_monitor_select};
  assign rd_gain_rate = {1'b0, amp_gain_code, output_rate_code};

  // Register storage; reserved bit 7 of gain/rate is not stored
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      internal_ref_control  <= `ARM_REFCTL_OFF;
      ref_input_select      <= 2'h0;
      system_monitor_select <= 3'h0;
      amp_gain_code         <= 3'h0;
      output_rate_code      <= 4'h0;
      clk_status            <= 1'b0;
    end else begin
      clk_status <= ext_clock_in_use;
      if (wr_ref_mon) begin
        internal_ref_control  <= wr_data[`ARM_REFCTL_HI:`ARM_REFCTL_LO];
        ref_input_select      <= wr_data[`ARM_REFSEL_HI:`ARM_REFSEL_LO];
        system_monitor_select <= wr_data[`ARM_MON_HI:`ARM_MON_LO];
      end
      if (wr_gain_rate) begin
        amp_gain_code    <= wr_data[`ARM_GAIN_HI:`ARM_GAIN_LO];
        output_rate_code <= wr_data[`ARM_RATE_HI:`ARM_RATE_LO];
      end
    end
  end

  // Reference power policy
  wire follow_mode   = internal_ref_control[1];
  wire next_follow   = (follow_on | conversion_active) & ~sleep_cmd & start_pin;
  wire ref_power_now = (internal_ref_control == `ARM_REFCTL_ON) ? 1'b1 :
                       (internal_ref_control == `ARM_REFCTL_OFF) ? 1'b0 :
                       next_follow;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      follow_on <= 1'b0;
    else
      follow_on <= follow_mode & next_follow;
  end

  // Monitor override and routing
  wire       overriding = (system_monitor_select != ARM_MON_NORMAL);
  wire       force_unity = system_monitor_select[2] | system_monitor_select[1];
  wire [1:0] eff_ref_sel = overriding ? `ARM_REFSEL_INT : ref_input_select;
  wire       drive_pair0 = ~overriding & (ref_input_select == `ARM_REFSEL_INT_DRV);
  arm_route_e route_now;
  assign route_now = (system_monitor_select == ARM_MON_NORMAL) ? ARM_ROUTE_CHANNEL :
                     (system_monitor_select == ARM_MON_OFFSET) ? ARM_ROUTE_MIDSUP :
                     ARM_ROUTE_INTERNAL;

  // Gain and rate decode
  wire [2:0] gain_code_eff = force_unity ? 3'h0 : amp_gain_code;
  wire [7:0] gain_now      = 8'h01 << gain_code_eff;
  wire [3:0] rate_idx      = (output_rate_code > `ARM_RATE_MAX_CODE) ?
                             (`ARM_RATE_MAX_CODE + 4'h1) : output_rate_code;
  logic [15:0] rate_now;
  always_comb begin
    case (rate_idx)
      4'h0:    rate_now = 16'h0005;
      4'h1:    rate_now = 16'h000A;
      4'h2:    rate_now = 16'h0014;
      4'h3:    rate_now = 16'h0028;
      4'h4:    rate_now = 16'h0050;
      4'h5:    rate_now = 16'h00A0;
      4'h6:    rate_now = 16'h0140;
      4'h7:    rate_now = 16'h0280;
      4'h8:    rate_now = 16'h03E8;
      default: rate_now = 16'h07D0;
    endcase
  end

  // Registered outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl            <= '{ref_power: 1'b0, ref_input_select: 2'h0, drive_ref_pair0: 1'b0,
                           override_active: 1'b0, route: ARM_ROUTE_CHANNEL,
                           source: ARM_MON_NORMAL, gain: 8'h01, rate_index: 4'h0};
      output_rate_sps <= 16'h0005;
    end else begin
      ctrl.ref_power        <= ref_power_now;
      ctrl.ref_input_select <= eff_ref_sel;
      ctrl.drive_ref_pair0  <= drive_pair0;
      ctrl.override_active  <= overriding;
      ctrl.route            <= route_now;
      ctrl.source           <= arm_mon_e'(system_monitor_select);
      ctrl.gain             <= gain_now;
      ctrl.rate_index       <= rate_idx;
      output_rate_sps       <= rate_now;
    end
  end
endmodule : arm_regs

// ===== test/arm_regs_props.sv
// Port checks for the reference/monitor/gain register block
`timescale 1ns/1ps
module arm_regs_props
  import arm_pkg::*;
(
  // Clock and reset
  input wire logic               mclk,
  input wire logic               sys_rst,
  // Bus
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic [5:0]         wb_adr_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  // Controls
  input wire arm_pkg::arm_ctrl_s ctrl,
  input wire logic [15:0]        output_rate_sps
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_RSVD_BIT: assert property (
    wb_ack_o && wb_adr_i == 6'h0C |-> wb_dat_o[31:7] == 25'h0)
    else $error("gain/rate bit 7 set");
  AST_OVR_FLAG: assert property (
    ctrl.override_active == (ctrl.source != ARM_MON_NORMAL))
    else $error("override flag wrong");
  AST_OVR_REF: assert property (
    ctrl.override_active |-> ctrl.ref_input_select == 2'h2)
    else $error("override reference wrong");
  AST_ROUTE: assert property (
    ctrl.route == (ctrl.source == ARM_MON_NORMAL ? ARM_ROUTE_CHANNEL :
    ctrl.source == ARM_MON_OFFSET ? ARM_ROUTE_MIDSUP : ARM_ROUTE_INTERNAL))
    else $error("route wrong");
  AST_GAIN_ONE: assert property (
    ctrl.source[2:1] != 2'h0 |-> ctrl.gain == 8'h01)
    else $error("gain not forced");
  AST_RATE_SAT: assert property (
    ctrl.rate_index == 4'h9 |-> output_rate_sps == 16'h07D0)
    else $error("top rate wrong");
  AST_DRIVE: assert property (
    ctrl.drive_ref_pair0 && !ctrl.override_active |-> ctrl.ref_input_select == 2'h3)
    else $error("pair0 drive wrong");
endmodule : arm_regs_props

// ===== test/arm_regs_tb_top.sv
// Self-checking bench for the reference/monitor/gain register block
`timescale 1ns/1ps
module arm_regs_tb_top;
  import arm_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        ext_clock_in_use, conversion_active, sleep_cmd, start_pin;
  logic [5:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] output_rate_sps;
  arm_ctrl_s   ctrl;
  int          err_count, checked;
  logic [15:0] rates [0:9] = '{16'h0005, 16'h000A, 16'h0014, 16'h0028, 16'h0050,
                               16'h00A0, 16'h0140, 16'h0280, 16'h03E8, 16'h07D0};
  arm_regs i_dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clock_in_use(ext_clock_in_use),
    .conversion_active(conversion_active), .sleep_cmd(sleep_cmd), .start_pin(start_pin),
    .ctrl(ctrl), .output_rate_sps(output_rate_sps));
  always #5 mclk = ~mclk;
  task complete_run;
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wb(input logic we, input logic [5:0] adr, input logic [7:0] dat, input logic [3:0] sel);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("ack_wait", 32'h2, n);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task settle;
    repeat (3) @(posedge mclk);
  endtask : settle
  task t_gain_rate;
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, 6'h0C, {1'b1, i[2:0], i[3:0]}, 4'hF);
      settle();
      chk("rate", rates[i > 8 ? 9 : i], output_rate_sps);
      chk("rate_index", i > 8 ? 32'h9 : i, ctrl.rate_index);
      chk("gain", 8'h01 << i[2:0], ctrl.gain);
      wb(1'b0, 6'h0C, 8'h00, 4'hF);
      chk("gain_rate", {25'h0, i[2:0], i[3:0]}, rd);
    end
  endtask : t_gain_rate
  task t_monitor;
    wb(1'b1, 6'h0C, 8'h50, 4'hF);
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, 6'h08, {3'h1, 2'h0, m[2:0]}, 4'hF);
      settle();
      chk("source", m[2:0], ctrl.source);
      chk("route", m == 0 ? 32'h1 : m == 1 ? 32'h2 : 32'h4, ctrl.route);
      chk("override", m > 0, ctrl.override_active);
      chk("gain", m < 2 ? 8'h20 : 8'h01, ctrl.gain);
      chk("refsel", m > 0 ? 2'h2 : 2'h0, ctrl.ref_input_select);
    end
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, 6'h08, {3'h1, s[1:0], 3'h0}, 4'hF);
      settle();
      chk("refsel", s[1:0], ctrl.ref_input_select);
      chk("drive", s == 3, ctrl.drive_ref_pair0);
    end
  endtask : t_monitor
  task pw(input logic [1:0] ctl, input logic exp);
    wb(1'b1, 6'h08, {1'b0, ctl, 5'h0}, 4'hF);
    settle();
    chk("ref_power", exp, ctrl.ref_power);
  endtask : pw
  task t_power;
    pw(2'h0, 1'b0);
    pw(2'h1, 1'b1);
    pw(2'h2, 1'b0);
    conversion_active <= 1'b1;
    pw(2'h2, 1'b1);
    conversion_active <= 1'b0;
    sleep_cmd <= 1'b1;
    pw(2'h2, 1'b0);
    sleep_cmd <= 1'b0;
    conversion_active <= 1'b1;
    pw(2'h3, 1'b1);
    conversion_active <= 1'b0;
    start_pin <= 1'b0;
    pw(2'h3, 1'b0);
  endtask : t_power
  task t_odd;
    wb(1'b1, 6'h10, 8'hA5, 4'hF);
    wb(1'b0, 6'h10, 8'h00, 4'hF);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 6'h0C, 8'h37, 4'hE);
    wb(1'b0, 6'h0C, 8'h00, 4'hF);
    chk("sel0_off", 32'h50, rd);
    ext_clock_in_use <= 1'b1;
    settle();
    wb(1'b0, 6'h08, 8'h00, 4'hF);
    chk("clkstat", 32'hE0, rd);
  endtask : t_odd
  // Mid-run reset must bring the gain/rate register, gain and rate outputs back to defaults
  task t_reset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    chk("rst2_gain", 8'h01, ctrl.gain);
    chk("rst2_rate", 16'h0005, output_rate_sps);
    wb(1'b0, 6'h0C, 8'h00, 4'hF);
    chk("rst2_gain_rate", 32'h0, rd);
  endtask : t_reset
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_clock_in_use, conversion_active, sleep_cmd} = 6'h00;
    {sys_rst, start_pin, wb_adr_i, wb_sel_i, wb_dat_i} = {2'h3, 42'h0};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    chk("rst_gain", 8'h01, ctrl.gain);
    chk("rst_rate", 16'h0005, output_rate_sps);
    wb(1'b0, 6'h08, 8'h00, 4'hF);
    chk("rst_ref_mon", 32'h0, rd);
    t_gain_rate();
    t_monitor();
    t_power();
    t_odd();
    t_reset();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    complete_run();
  end
endmodule : arm_regs_tb_top
bind arm_regs arm_regs_props i_props (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ctrl(ctrl), .output_rate_sps(output_rate_sps));
